/* File: rtl/sram_ctrl_defines.svh */
// Purpose: Timing and geometry constants for the static RAM controller.
// Assumes: 250 MHz controller clock, 4 ns period.
// Notes:   Times in ns; cycle counts are derived and rounded up.
`ifndef SRAM_CTRL_DEFINES_SVH
`define SRAM_CTRL_DEFINES_SVH

`define CLK_PERIOD_NS        4
`define ADDR_WIDTH           14
`define WORD_COUNT           16384
// Slower grade figures; they also cover the faster grade
`define WRITE_CYCLE_NS       70
`define ADDRESS_TO_WRITE_END_NS 50
`define CE_TO_WRITE_END_NS   60
`define DATA_TO_WRITE_END_NS 45
`define READ_CYCLE_NS        70
`define DIV_UP(t)            (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLES         `DIV_UP(`WRITE_CYCLE_NS)
`define CE_WRITE_CYCLES      `DIV_UP(`CE_TO_WRITE_END_NS)
`define ADDR_WRITE_CYCLES    `DIV_UP(`ADDRESS_TO_WRITE_END_NS)
`define DATA_WRITE_CYCLES    `DIV_UP(`DATA_TO_WRITE_END_NS)
`define READ_CYCLES          `DIV_UP(`READ_CYCLE_NS)
`define CNT_WIDTH            5

`endif

/* File: rtl/sram_ctrl_pkg.sv */
// Purpose: Types for the static RAM controller.
// Assumes: Defines header is available.
// Notes:   Holds only types.
`include "sram_ctrl_defines.svh"
package sram_ctrl_pkg;
   typedef logic [`ADDR_WIDTH-1:0] addr_t;
   typedef logic [`CNT_WIDTH-1:0]  count_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE,
      ST_RECOVER
   } state_t;
endpackage

/* File: rtl/phase_timer.sv */
// Purpose: Down-counter that times one phase of a RAM access.
// Assumes: Load and count never coincide with reset.
// Notes:   Done is registered; it rises the cycle the count reaches one.
`timescale 1ns/1ps
module phase_timer
   import sram_ctrl_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_reset,
   input  wire logic                 i_load,
   input  wire sram_ctrl_pkg::count_t i_count,
   output logic                      o_done
);
   count_t count_reg;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         count_reg <= '0;
      end else if (i_load) begin
         count_reg <= i_count;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - count_t'(1);
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_done <= 1'b0;
      end else begin
         o_done <= !i_load && (count_reg == count_t'(2));
      end
   end
endmodule

/* File: rtl/sram_host_ctrl.sv */
// Purpose: Host-side controller driving a 16K x 1 asynchronous static RAM.
// Assumes: Request inputs synchronous to I_CLK; RAM pins go straight out.
// Notes:   All pins come from flip-flops, so no pin glitches mid-access.
//          Slower-grade figures are used throughout; they cover the faster
//          grade too, at the cost of a few cycles per access.
`timescale 1ns/1ps
`include "sram_ctrl_defines.svh"

// Operation
// RQ1: The RAM holds 16384 one-bit words on a 14-bit address with separate data in and out.
// RQ2: Chip enable and write strobe low write, enable low with strobe high reads, enable high deselects.
// RQ3: The write strobe stays high for the whole of every read.
// RQ4: Address changes only while chip enable or write strobe is high.
// RQ5: Ending a write by raising enable and strobe together leaves the RAM output floating.
// RQ6: Raising chip enable puts the RAM into standby on its own.
// RQ7: Lowering chip enable powers the RAM up on its own.
// RQ8: Successive writes start at least one write cycle apart.
// RQ9: The address is valid a set time before the write ends.
// RQ10: Chip enable is low a set time before the write ends.
// RQ11: Write data are valid a set time before the write ends.
// RQ12: The RAM floats its output within a set time of the write strobe falling.
// RQ13: The RAM may drive its output again as soon as a write ends.
module sram_host_ctrl
   import sram_ctrl_pkg::*;
(
   input  wire logic                 I_CLK,
   input  wire logic                 I_RESET,
   input  wire logic                 I_REQ,
   input  wire logic                 I_WRITE,
   input  wire sram_ctrl_pkg::addr_t I_ADDR,
   input  wire logic                 I_WDATA,
   input  wire logic                 I_RAM_DOUT,
   output logic                      O_READY,
   output logic                      O_RDATA,
   output logic                      O_RDATA_VALID,
   output sram_ctrl_pkg::addr_t      O_RAM_ADDR,
   output logic                      O_RAM_CE_N,
   output logic                      O_RAM_WE_N,
   output logic                      O_RAM_DIN
);
   import sram_ctrl_pkg::*;

   // Each write-end setup rounded up to whole cycles; the strobe pair
   // stays low for the longest of them, so one hold covers all four
   localparam int CYCLE_HOLD = `WRITE_CYCLES;      // RQ8
   localparam int ADDR_HOLD  = `ADDR_WRITE_CYCLES; // RQ9
   localparam int CE_HOLD    = `CE_WRITE_CYCLES;   // RQ10
   localparam int DATA_HOLD  = `DATA_WRITE_CYCLES; // RQ11

   // Read held a full cycle time so the data pin has settled at the end
   localparam int READ_HOLD  = `READ_CYCLES;

   // Constant function, used at elaboration only
   function automatic int larger(input int a, input int b);
      if (a > b) begin
         return a;
      end else begin
         return b;
      end
   endfunction

   localparam int WE_HOLD = larger(larger(CYCLE_HOLD, ADDR_HOLD),
                                   larger(CE_HOLD, DATA_HOLD));

   // Sequencer state, phase timer handshake and pin next values
   state_t state_reg;
   state_t state_next;
   logic   timer_load;
   count_t timer_count;
   logic   timer_done;
   logic   take;
   logic   read_end;
   logic   ce_n_next;
   logic   we_n_next;
   logic   ready_next;

   // One timer serves both kinds of access; they never overlap
   phase_timer u_timer (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_load  (timer_load),
      .i_count (timer_count),
      .o_done  (timer_done)
   );

   // A request is taken only from idle; one held high while busy is taken once idle
   assign take     = (state_reg == ST_IDLE) && I_REQ;
   assign read_end = (state_reg == ST_READ) && timer_done;

   // Access sequencer: idle, one timed phase, then for writes one
   // recovery cycle before the next access may start
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take && I_WRITE) begin
               state_next = ST_WRITE; // RQ2
            end else if (take) begin
               state_next = ST_READ; // RQ2
            end
         end
         ST_READ: begin
            // Data pin sampled on this same edge
            if (timer_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_WRITE: begin
            // Both strobes rise together on the edge after the hold
            if (timer_done) begin
               state_next = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            // One idle cycle with strobes high: write recovery and hold
            state_next = ST_IDLE;
         end
         default: begin
            // Unused codes fall back to idle
            state_next = ST_IDLE;
         end
      endcase
   end

   // Phase length loaded on the take edge; the timer then runs alone
   always_comb begin
      timer_load  = 1'b0;
      timer_count = '0;
      case (state_reg)
         ST_IDLE: begin
            timer_load = take;
            if (I_WRITE) begin
               timer_count = count_t'(WE_HOLD); // RQ8 RQ9 RQ10 RQ11
            end else begin
               timer_count = count_t'(READ_HOLD);
            end
         end
         default: begin
            timer_load = 1'b0;
         end
      endcase
   end

   // Pin levels follow the next state so they change on the same edge
   // as the state, without a cycle of lag
   assign ce_n_next  = !(state_next == ST_READ || state_next == ST_WRITE);
   assign we_n_next  = (state_next != ST_WRITE);
   assign ready_next = (state_next == ST_IDLE);

   // Reset returns to idle with both strobes high
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Address latched only on the take edge, while both strobes are high,
   // so it never moves inside a selected write
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_RAM_ADDR <= '0;
      end else if (take) begin
         O_RAM_ADDR <= I_ADDR; // RQ4 RQ1
      end
   end

   // Write data set up with the address and held through the whole
   // strobe, far longer than the data setup asks
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_RAM_DIN <= 1'b0;
      end else if (take && I_WRITE) begin
         O_RAM_DIN <= I_WDATA; // RQ11
      end
   end

   // Enable low only within an access; high leaves the RAM in standby
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_RAM_CE_N <= 1'b1;
      end else begin
         O_RAM_CE_N <= ce_n_next; // RQ6 RQ7
      end
   end

   // Strobe falls with enable and both rise together at write end,
   // so the RAM output stays floating as the write closes
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_RAM_WE_N <= 1'b1;
      end else begin
         O_RAM_WE_N <= we_n_next; // RQ3 RQ5 RQ10
      end
   end

   // Read data sampled on the last cycle of the read, when the access
   // time has run out; held until the next read completes
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_RDATA <= 1'b0;
      end else if (read_end) begin
         O_RDATA <= I_RAM_DOUT; // RQ2
      end
   end

   // One-cycle pulse on the same edge as the sampled bit
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_RDATA_VALID <= 1'b0;
      end else begin
         O_RDATA_VALID <= read_end;
      end
   end

   // Ready follows the next state, so it rises on the edge the sequencer returns
   // to idle; a waiting request is taken on the edge after that
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_READY <= 1'b0;
      end else begin
         O_READY <= ready_next; // RQ8
      end
   end
endmodule

/* File: testbench/sram_host_props.sv */
// Purpose: Pin timing checks for the RAM controller.
// Assumes: One clock; write figures in 4 ns cycles.
// Notes:   Write start spacing is counted in helper logic.
`timescale 1ns/1ps
module sram_host_props
   import sram_ctrl_pkg::*;
(
   input wire logic                 I_CLK,
   input wire logic                 I_RESET,
   input wire sram_ctrl_pkg::addr_t O_RAM_ADDR,
   input wire logic                 O_RAM_CE_N,
   input wire logic                 O_RAM_WE_N,
   input wire logic                 O_RAM_DIN
);
   logic [4:0] gap_reg;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   sequence wr_open; $fell(O_RAM_WE_N); endsequence
   sequence wr_close; $rose(O_RAM_WE_N); endsequence
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) gap_reg <= 5'h1f;
      else if ($fell(O_RAM_WE_N)) gap_reg <= 5'h01;
      else if (gap_reg != 5'h1f) gap_reg <= gap_reg + 5'h01;
   end
   a_we_opens_only: assert property (wr_open |-> $fell(O_RAM_CE_N))
      else $error("write strobe fell inside a read");
   a_addr_held: assert property (!O_RAM_CE_N && !O_RAM_WE_N
      && !$past(O_RAM_CE_N) && !$past(O_RAM_WE_N) |-> $stable(O_RAM_ADDR))
      else $error("address moved during a write");
   a_write_gap: assert property (wr_open |-> gap_reg >= 5'h12)
      else $error("writes started too close together");
   a_addr_lead: assert property (wr_close |-> !$past(O_RAM_WE_N, 13)
      && $past(O_RAM_ADDR, 13) == $past(O_RAM_ADDR, 1))
      else $error("address valid too briefly before write end");
   a_ce_lead: assert property (wr_close |-> !$past(O_RAM_CE_N, 15))
      else $error("chip enable low too briefly before write end");
   a_data_lead: assert property (wr_close |-> !$past(O_RAM_WE_N, 12)
      && $past(O_RAM_DIN, 12) == $past(O_RAM_DIN, 1))
      else $error("write data valid too briefly before write end");
endmodule
bind sram_host_ctrl sram_host_props chk (.I_CLK(I_CLK), .I_RESET(I_RESET),
   .O_RAM_ADDR(O_RAM_ADDR), .O_RAM_CE_N(O_RAM_CE_N),
   .O_RAM_WE_N(O_RAM_WE_N), .O_RAM_DIN(O_RAM_DIN));

/* File: testbench/ram_model.sv */
// Purpose: Behavioural 16K x 1 static RAM for the controller bench.
// Assumes: Zero pin delays; a write lands as the strobe pair rises.
// Notes:   Floating output toggles each cycle so it never passes as data.
`timescale 1ns/1ps
module ram_model
   import sram_ctrl_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire sram_ctrl_pkg::addr_t i_addr,
   input  wire logic                 i_ce_n,
   input  wire logic                 i_we_n,
   input  wire logic                 i_din,
   output logic                      o_dout
);
   logic mem [0:16383];
   logic float_reg;
   logic standby_current;
   assign standby_current = i_ce_n;
   always @(posedge i_clk) float_reg <= (float_reg === 1'b1) ? 1'b0 : 1'b1;
   always @(posedge (i_ce_n | i_we_n)) mem[i_addr] <= i_din;
   // Drives only while selected and not writing; standby floats
   assign o_dout = (!standby_current && i_we_n) ? mem[i_addr]
      : float_reg;
endmodule

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the static RAM controller.
// Assumes: Inputs change on the falling edge.
// Notes:   Reads revisit written words only; others are undefined.
`timescale 1ns/1ps
`include "sram_ctrl_defines.svh"
module testbench;
   import sram_ctrl_pkg::*;
   logic        I_CLK, I_RESET, I_REQ, I_WRITE, I_WDATA, I_RAM_DOUT;
   logic        O_READY, O_RDATA, O_RDATA_VALID, O_RAM_CE_N, O_RAM_WE_N;
   logic        O_RAM_DIN;
   addr_t       I_ADDR, O_RAM_ADDR, a;
   logic        ref_mem [0:16383];
   addr_t       aq [$];
   logic [31:0] seed;
   int          err_total, compares, cyc;
   sram_host_ctrl dut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_REQ(I_REQ),
      .I_WRITE(I_WRITE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_RAM_DOUT(I_RAM_DOUT), .O_READY(O_READY), .O_RDATA(O_RDATA),
      .O_RDATA_VALID(O_RDATA_VALID), .O_RAM_ADDR(O_RAM_ADDR),
      .O_RAM_CE_N(O_RAM_CE_N), .O_RAM_WE_N(O_RAM_WE_N), .O_RAM_DIN(O_RAM_DIN));
   ram_model ram (.i_clk(I_CLK), .i_addr(O_RAM_ADDR), .i_ce_n(O_RAM_CE_N),
      .i_we_n(O_RAM_WE_N), .i_din(O_RAM_DIN), .o_dout(I_RAM_DOUT));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (e !== g) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic chk_latency(input logic [31:0] e, g);
      chk("latency", e, g);
   endtask
   task automatic chk_rdata(input logic e, g);
      chk("rdata", {31'h0, e}, {31'h0, g});
   endtask
   task automatic close_out;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic op(input logic w, input addr_t ad, input logic d);
      int n;
      n = 0;
      I_REQ = 1'b1;
      I_WRITE = w;
      I_ADDR = ad;
      I_WDATA = d;
      @(negedge I_CLK);
      I_REQ = 1'b0;
      while ((w ? O_READY : O_RDATA_VALID) !== 1'b1 && n < 40) begin
         @(negedge I_CLK);
         n++;
      end
      // Write: full write cycle plus one recovery cycle; read: read cycle
      chk_latency(w ? `WRITE_CYCLES + 1 : `READ_CYCLES, n);
      if (!w) chk_rdata(ref_mem[ad], O_RDATA);
      else ref_mem[ad] = d;
   endtask
   initial begin
      I_CLK = 1'b0;
      forever #2 I_CLK = ~I_CLK;
   end
   // Ceiling well above the few hundred cycles of traffic
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      I_RESET = 1'b1;
      I_REQ = 1'b0;
      I_WRITE = 1'b0;
      I_ADDR = 14'h0000;
      I_WDATA = 1'b0;
      seed = 32'hddf5;
      repeat (5) @(negedge I_CLK);
      I_RESET = 1'b0;
      repeat (2) @(negedge I_CLK);
      for (int i = 0; i < 14; i++) begin
         seed = lfsr(seed);
         a = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3fff : seed[13:0];
         op(1'b1, a, seed[20]);
         aq.push_back(a);
         // Back-to-back readback of the word just written
         if (i[0]) op(1'b0, a, 1'b0);
      end
      foreach (aq[k]) op(1'b0, aq[k], 1'b0);
      close_out();
   end
endmodule
